// [hdl/ifpc_flash_seq.sv]
// sequencer for in-application flash read, page erase and byte program
// assumes the processor honours cpu_stall and drives sfr_* on clk_sys
`timescale 1ns/10ps
`default_nettype none
module ifpc_flash_seq #(
  parameter int MAIN_BYTES = 16384,
  parameter int BOOT_BYTES = 4096,
  parameter int CFG_BYTES = 8,
  parameter logic [15:0] PROG_WAIT = 16'h0010,
  parameter logic [15:0] ERASE_WAIT = 16'h0040
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // special-function register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // control bits held elsewhere in the chip
  input wire logic programming_enable,
  input wire logic ext_clk_sel,
  input wire logic main_array_update_enable,
  input wire logic boot_array_update_enable,
  input wire logic config_update_enable,
  input wire logic fault_clear,
  // status and system controls
  output logic program_fault_flag,
  output logic seq_busy,
  output logic cpu_stall,
  output logic internal_rc_oscillator_en
);
  localparam int TOTAL = MAIN_BYTES + BOOT_BYTES + CFG_BYTES;
  localparam int IDX_W = $clog2(TOTAL);
  localparam int BOOT_BASE = MAIN_BYTES;
  localparam int CFG_BASE = MAIN_BYTES + BOOT_BYTES;
  // counter steps; the key window is shut once its count reaches zero
  localparam logic [3:0] KEY_SHUT = 4'h0;
  localparam logic [3:0] KEY_STEP = 4'h1;
  localparam logic [15:0] CNT_STEP = 16'h0001;
  localparam int LEN_STEP = 1;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] addr_hi;
    logic [7:0] addr_lo;
    logic [7:0] data;
    logic [7:0] rdata;
    logic fault;
    logic busy;
    logic stall;
    logic osc_en;
    logic key_armed;
    logic [3:0] key_cnt;
    ifpc_pkg::ifpc_state_t state;
    logic [IDX_W-1:0] idx;
    logic [15:0] cnt;
  } ifpc_regs_t;

  ifpc_regs_t s_ff;
  ifpc_regs_t nxt_s;

  // flash cells: no reset, contents survive a reset as real flash would
  // never-written cells read unknown, so erase before the first read
  logic [7:0] mem [TOTAL];

  logic mem_we;
  logic [IDX_W-1:0] mem_widx;
  logic [7:0] mem_wdat;
  logic [1:0] grp;
  logic [1:0] stb;
  logic [3:0] ctrl;
  logic [15:0] tgt;
  logic is_read;
  logic is_prog;
  logic is_erase;
  logic grp_ok;
  logic in_range;
  logic upd_ok;
  logic cmd_ok;
  logic go;
  logic set_fault;
  int unsigned lim;
  int unsigned base;
  int unsigned erase_len;

  always_comb begin
    nxt_s = s_ff;
    mem_we = 1'b0;
    mem_widx = s_ff.idx;
    mem_wdat = s_ff.data;
    set_fault = 1'b0;
    // command decode
    grp = s_ff.cmd[ifpc_pkg::GRP_HI:ifpc_pkg::GRP_LO];
    stb = {s_ff.cmd[ifpc_pkg::OSTB_BIT], s_ff.cmd[ifpc_pkg::CSTB_BIT]};
    ctrl = s_ff.cmd[ifpc_pkg::CTRL_HI:ifpc_pkg::CTRL_LO];
    tgt = {s_ff.addr_hi, s_ff.addr_lo};
    is_read = (ctrl == ifpc_pkg::CTRL_READ) && (stb == ifpc_pkg::STB_READ);
    is_prog = (ctrl == ifpc_pkg::CTRL_PROG) && (stb == ifpc_pkg::STB_WRITE);
    is_erase = (ctrl == ifpc_pkg::CTRL_ERASE) && (stb == ifpc_pkg::STB_WRITE);
    case (grp)
      ifpc_pkg::GRP_MAIN: begin
        grp_ok = 1'b1;
        lim = MAIN_BYTES;
        base = 0;
        erase_len = ifpc_pkg::PAGE_BYTES;
        upd_ok = main_array_update_enable;
      end
      ifpc_pkg::GRP_BOOT: begin
        grp_ok = 1'b1;
        lim = BOOT_BYTES;
        base = BOOT_BASE;
        erase_len = ifpc_pkg::PAGE_BYTES;
        upd_ok = boot_array_update_enable;
      end
      ifpc_pkg::GRP_CFG: begin
        grp_ok = 1'b1;
        lim = CFG_BYTES;
        base = CFG_BASE;
        erase_len = CFG_BYTES;
        upd_ok = config_update_enable;
      end
      default: begin
        grp_ok = 1'b0;
        lim = 0;
        base = 0;
        erase_len = 1;
        upd_ok = 1'b0;
      end
    endcase
    in_range = 32'(tgt) < lim;
    // lock configuration is deliberately not part of this check
    cmd_ok = grp_ok && in_range && (is_read || ((is_prog || is_erase) && upd_ok));

    // timed-access window
    if (s_ff.key_cnt != KEY_SHUT) begin
      nxt_s.key_cnt = s_ff.key_cnt - KEY_STEP;
    end
    if (sfr_wr) begin
      nxt_s.key_armed = 1'b0;
      if (sfr_addr == ifpc_pkg::KEY_OFS) begin
        if (sfr_wdata == ifpc_pkg::KEY_FIRST) begin
          nxt_s.key_armed = 1'b1;
        end else if (s_ff.key_armed && sfr_wdata == ifpc_pkg::KEY_SECOND) begin
          nxt_s.key_cnt = ifpc_pkg::KEY_OPEN_CYC;
        end
      end else if (sfr_addr == ifpc_pkg::TRIG_OFS) begin
        // a protected write spends the window whether or not it starts anything
        nxt_s.key_cnt = KEY_SHUT;
      end
    end
    // a refused trigger leaves no trace: no fault, no busy, window spent
    go = sfr_wr && (sfr_addr == ifpc_pkg::TRIG_OFS) && sfr_wdata[ifpc_pkg::GO_BIT] &&
         (s_ff.key_cnt != KEY_SHUT) && programming_enable &&
         (s_ff.state == ifpc_pkg::ST_IDLE);

    // plain register writes
    // dropped during a job so the running address cannot shift under it
    if (sfr_wr && !s_ff.busy) begin
      case (sfr_addr)
        ifpc_pkg::CMD_OFS: nxt_s.cmd = sfr_wdata;
        ifpc_pkg::ADDR_HI_OFS: nxt_s.addr_hi = sfr_wdata;
        ifpc_pkg::ADDR_LO_OFS: nxt_s.addr_lo = sfr_wdata;
        ifpc_pkg::DATA_OFS: nxt_s.data = sfr_wdata;
        default: begin
        end
      endcase
    end

    // sequencer
    case (s_ff.state)
      ifpc_pkg::ST_IDLE: begin
        if (go) begin
          if (!cmd_ok) begin
            set_fault = 1'b1;
          end else begin
            nxt_s.busy = 1'b1;
            if (is_read) begin
              nxt_s.state = ifpc_pkg::ST_READ;
              nxt_s.idx = IDX_W'(base + 32'(tgt));
            end else if (is_prog) begin
              nxt_s.state = ifpc_pkg::ST_PROG;
              nxt_s.idx = IDX_W'(base + 32'(tgt));
            end else begin
              nxt_s.state = ifpc_pkg::ST_ERASE;
              // config is one erase unit, so its erase starts at the region base
              nxt_s.idx = (grp == ifpc_pkg::GRP_CFG) ? IDX_W'(base) :
                          IDX_W'(base + 32'(tgt & ifpc_pkg::PAGE_MASK));
              nxt_s.cnt = 16'(erase_len - LEN_STEP);
            end
          end
        end
      end
      ifpc_pkg::ST_READ: begin
        nxt_s.data = mem[s_ff.idx];
        nxt_s.busy = 1'b0;
        nxt_s.state = ifpc_pkg::ST_IDLE;
      end
      ifpc_pkg::ST_PROG: begin
        mem_we = 1'b1;
        nxt_s.cnt = PROG_WAIT;
        nxt_s.state = ifpc_pkg::ST_SETTLE;
      end
      ifpc_pkg::ST_ERASE: begin
        mem_we = 1'b1;
        mem_wdat = ifpc_pkg::ERASED_BYTE;
        nxt_s.idx = s_ff.idx + IDX_W'(1);
        if (s_ff.cnt == ifpc_pkg::CNT_ZERO) begin
          nxt_s.cnt = ERASE_WAIT;
          nxt_s.state = ifpc_pkg::ST_SETTLE;
        end else begin
          nxt_s.cnt = s_ff.cnt - CNT_STEP;
        end
      end
      ifpc_pkg::ST_SETTLE: begin
        // cells recover here; the stall keeps software off the array meanwhile
        if (s_ff.cnt == ifpc_pkg::CNT_ZERO) begin
          nxt_s.busy = 1'b0;
          nxt_s.state = ifpc_pkg::ST_IDLE;
        end else begin
          nxt_s.cnt = s_ff.cnt - CNT_STEP;
        end
      end
      default: begin
        nxt_s.busy = 1'b0;
        nxt_s.state = ifpc_pkg::ST_IDLE;
      end
    endcase
    nxt_s.stall = nxt_s.busy;

    // sticky fault: a new fault beats a clear in the same cycle
    if (fault_clear) begin
      nxt_s.fault = 1'b0;
    end
    if (set_fault) begin
      nxt_s.fault = 1'b1;
    end

    // oscillator stays up while a job is still running
    // with the internal clock as system clock it stays on except in reset, which clears it
    nxt_s.osc_en = programming_enable || !ext_clk_sel || nxt_s.busy;

    // registered read data; trigger and key read as zero
    // data lasts one cycle; idle cycles show zero so no stale byte leaks
    nxt_s.rdata = ifpc_pkg::BYTE_RST;
    if (sfr_rd) begin
      case (sfr_addr)
        ifpc_pkg::CMD_OFS: nxt_s.rdata = s_ff.cmd;
        ifpc_pkg::ADDR_HI_OFS: nxt_s.rdata = s_ff.addr_hi;
        ifpc_pkg::ADDR_LO_OFS: nxt_s.rdata = s_ff.addr_lo;
        ifpc_pkg::DATA_OFS: nxt_s.rdata = s_ff.data;
        ifpc_pkg::TRIG_OFS: nxt_s.rdata = ifpc_pkg::BYTE_RST;
        default: nxt_s.rdata = ifpc_pkg::BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '0;
      s_ff.cmd <= ifpc_pkg::CMD_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_widx] <= mem_wdat;
    end
  end

  assign sfr_rdata = s_ff.rdata;
  assign program_fault_flag = s_ff.fault;
  assign seq_busy = s_ff.busy;
  assign cpu_stall = s_ff.stall;
  assign internal_rc_oscillator_en = s_ff.osc_en;
endmodule
`default_nettype wire

// [hdl/ifpc_pkg.sv]
// constants and types of the in-application flash program sequencer
// assumes the processor special-function bus runs on the same clock
package ifpc_pkg;
  // register offsets on the special-function bus
  localparam logic [7:0] TRIG_OFS = 8'ha4;
  localparam logic [7:0] ADDR_LO_OFS = 8'ha6;
  localparam logic [7:0] ADDR_HI_OFS = 8'ha7;
  localparam logic [7:0] DATA_OFS = 8'hae;
  localparam logic [7:0] CMD_OFS = 8'haf;
  localparam logic [7:0] KEY_OFS = 8'hc7;
  // reset values
  localparam logic [7:0] CMD_RST = 8'h30;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // timed-access unlock
  localparam logic [7:0] KEY_FIRST = 8'haa;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [3:0] KEY_OPEN_CYC = 4'h4;
  // command byte layout; GO_BIT is bit 0 of the trigger write
  localparam int GO_BIT = 0;
  localparam int GRP_HI = 7;
  localparam int GRP_LO = 6;
  localparam int OSTB_BIT = 5;
  localparam int CSTB_BIT = 4;
  localparam int CTRL_HI = 3;
  localparam int CTRL_LO = 0;
  localparam logic [3:0] CTRL_READ = 4'h0;
  localparam logic [3:0] CTRL_PROG = 4'h1;
  localparam logic [3:0] CTRL_ERASE = 4'h2;
  localparam logic [1:0] STB_READ = 2'h0;
  localparam logic [1:0] STB_WRITE = 2'h2;
  localparam logic [1:0] GRP_MAIN = 2'h0;
  localparam logic [1:0] GRP_BOOT = 2'h1;
  localparam logic [1:0] GRP_CFG = 2'h3;
  // array geometry
  localparam int PAGE_BYTES = 128;
  localparam logic [15:0] PAGE_MASK = 16'hff80;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  typedef enum logic [2:0] {ST_IDLE, ST_READ, ST_PROG, ST_ERASE, ST_SETTLE} ifpc_state_t;
endpackage

// [testbench/ifpc_flash_seq_test.sv]
// self-checking bench for the flash sequencer
// assumes the checker binds itself from its own file
`timescale 1ns/10ps
`default_nettype none
module ifpc_flash_seq_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic programming_enable = 1'b0;
  logic ext_clk_sel = 1'b0;
  logic main_array_update_enable = 1'b0;
  logic boot_array_update_enable = 1'b0;
  logic config_update_enable = 1'b0;
  logic fault_clear = 1'b0;
  logic program_fault_flag, seq_busy, cpu_stall, internal_rc_oscillator_en;
  int n_mismatch = 0;
  int n_checks = 0;
  integer seed = 32'h90e041d5;
  logic [7:0] exp_q[$];
  logic rd_d = 1'b0;
  logic [7:0] d;
  logic [6:0] ofs;
  always #5 clk_sys = ~clk_sys;
  // short settle counts keep the wait after each program and erase brief
  ifpc_flash_seq #(.PROG_WAIT(16'h0002), .ERASE_WAIT(16'h0004)) u_ifpc_flash_seq (
    .clk_sys, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .programming_enable, .ext_clk_sel, .main_array_update_enable,
    .boot_array_update_enable, .config_update_enable, .fault_clear,
    .program_fault_flag, .seq_busy, .cpu_stall, .internal_rc_oscillator_en);
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    sfr_wr = 1'b1;
    sfr_addr = a;
    sfr_wdata = v;
    @(negedge clk_sys);
    sfr_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfr_rd = 1'b1;
    sfr_addr = a;
    exp_q.push_back(e);
    @(negedge clk_sys);
    sfr_rd = 1'b0;
  endtask
  // read data lands one cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_d)
      chk(sfr_rdata, exp_q.pop_front());
    rd_d <= sfr_rd;
  end
  task automatic op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] v,
                    input bit key);
    int i;
    wr(8'haf, c);
    wr(8'ha7, a[15:8]);
    wr(8'ha6, a[7:0]);
    wr(8'hae, v);
    if (key) begin
      wr(8'hc7, 8'haa);
      wr(8'hc7, 8'h55);
    end
    wr(8'ha4, 8'h01);
    for (i = 0; i < 400 && seq_busy !== 1'b0; i++)
      @(negedge clk_sys);
    if (seq_busy !== 1'b0) begin
      n_mismatch++;
      $display("ERROR %0t busy never fell", $time);
    end
  endtask
  task automatic rdb(input logic [15:0] a, input logic [7:0] e);
    op(8'h00, a, 8'h00, 1'b1);
    rd(8'hae, e);
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rst_b = 1'b1;
    rd(8'haf, 8'h30);
    rd(8'ha7, 8'h00);
    rd(8'ha6, 8'h00);
    rd(8'hae, 8'h00);
    d = $random(seed);
    ofs = $random(seed);
    programming_enable = 1'b1;
    main_array_update_enable = 1'b1;
    op(8'h22, {9'h004, ofs}, 8'hff, 1'b1);
    rdb(16'h0200, 8'hff);
    rdb(16'h027f, 8'hff);
    op(8'h21, {9'h004, ofs}, d, 1'b1);
    rdb({9'h004, ofs}, d);
    op(8'h21, {9'h004, ofs}, ~d, 1'b0);
    rd(8'ha4, 8'h00);
    programming_enable = 1'b0;
    ext_clk_sel = 1'b1;
    op(8'h21, {9'h004, ofs}, ~d, 1'b1);
    chk({7'h00, internal_rc_oscillator_en}, 8'h00);
    programming_enable = 1'b1;
    ext_clk_sel = 1'b0;
    rdb({9'h004, ofs}, d);
    main_array_update_enable = 1'b0;
    op(8'h21, {9'h004, ofs}, ~d, 1'b1);
    chk({7'h00, program_fault_flag}, 8'h01);
    fault_clear = 1'b1;
    @(negedge clk_sys);
    fault_clear = 1'b0;
    chk({7'h00, program_fault_flag}, 8'h00);
    rdb({9'h004, ofs}, d);
    op(8'h80, 16'h0000, 8'h00, 1'b1);
    chk({7'h00, program_fault_flag}, 8'h01);
    give_verdict();
  end
  // a hung handshake ends the run here
  initial begin
    #100000;
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire

// [testbench/ifpc_seq_asserts.sv]
// port checker for the flash sequencer
// assumes it is bound onto ifpc_flash_seq
`timescale 1ns/10ps
`default_nettype none
module ifpc_seq_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  // controls
  input wire logic programming_enable,
  input wire logic ext_clk_sel,
  input wire logic fault_clear,
  // status
  input wire logic program_fault_flag,
  input wire logic seq_busy,
  input wire logic cpu_stall,
  input wire logic internal_rc_oscillator_en
);
  localparam int MAXB = 1000;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence s_go;
    sfr_wr && sfr_addr == 8'ha4 && sfr_wdata[0];
  endsequence
  sequence s_trig_read;
    sfr_rd && sfr_addr == 8'ha4;
  endsequence
  a_stall_is_busy: assert property (cpu_stall == seq_busy)
    else $error("stall differs from busy");
  a_start_needs_go: assert property (!sfr_wr && !seq_busy |=> !seq_busy)
    else $error("busy without a go write");
  a_disabled_idle: assert property (!programming_enable && !seq_busy |=> !seq_busy)
    else $error("started while disabled");
  a_busy_bounded: assert property ($rose(seq_busy) |-> ##[1:MAXB] !seq_busy)
    else $error("busy never ends");
  a_fault_sticky: assert property (program_fault_flag && !fault_clear |=> program_fault_flag)
    else $error("fault flag lost");
  a_fault_skips: assert property ($rose(program_fault_flag) |-> !seq_busy)
    else $error("faulty operation ran");
  a_trig_reads_zero: assert property (s_trig_read |=> sfr_rdata == 8'h00)
    else $error("trigger read not zero");
  a_osc_on_enable: assert property (programming_enable |=> internal_rc_oscillator_en)
    else $error("oscillator off while enabled");
  a_osc_off_ext: assert property (!programming_enable && ext_clk_sel && !seq_busy
    |=> !internal_rc_oscillator_en)
    else $error("oscillator left running");
  a_no_fault_disabled: assert property (!programming_enable && !program_fault_flag
    |=> !program_fault_flag)
    else $error("fault while disabled");
  c_go: cover property (s_go);
endmodule
bind ifpc_flash_seq ifpc_seq_chk u_chk (.clk_sys, .rst_b, .sfr_addr, .sfr_wr, .sfr_rd,
  .sfr_wdata, .sfr_rdata, .programming_enable, .ext_clk_sel, .fault_clear,
  .program_fault_flag, .seq_busy, .cpu_stall, .internal_rc_oscillator_en);
`default_nettype wire
